// ### cefl_event_flags.sv
// Charger event flag latches, masks of the charge fault and converter flags, and register access port
`timescale 1ns/1ps
`include "cefl_regs.svh"

module cefl_event_flags
	import cefl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire cefl_byte_t reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire cefl_byte_t reg_wdata,
	output cefl_byte_t reg_rdata,
	input wire logic input_overvoltage_event,
	input wire logic battery_overcurrent_event,
	input wire logic battery_undervoltage_event,
	input wire logic thermistor_cold_entry_event,
	input wire logic thermistor_cool_entry_event,
	input wire logic thermistor_warm_entry_event,
	input wire logic thermistor_hot_entry_event,
	input wire logic adc_conversion_done_event,
	input wire logic comparator_one_cross_event,
	input wire logic comparator_two_cross_event,
	input wire logic comparator_three_cross_event,
	input wire logic thermistor_open_event,
	input wire logic host_watchdog_expiry_event,
	input wire logic charge_safety_expiry_event,
	input wire logic regulator_overcurrent_event,
	input wire logic current_limit_pin_open_event,
	input wire logic button_wake_first_event,
	input wire logic button_wake_second_event,
	input wire logic button_reset_warning_event,
	output cefl_byte_t charge_fault_flags,
	output cefl_byte_t converter_flags,
	output cefl_byte_t system_fault_flags,
	output cefl_byte_t charge_fault_mask,
	output cefl_byte_t converter_event_mask,
	output cefl_byte_t charge_fault_pending,
	output cefl_byte_t converter_pending
);
	cefl_sel_t sel;
	cefl_byte_t rdata_q;
	cefl_byte_t rdata_d;
	cefl_byte_t cf_pend_q;
	cefl_byte_t cv_pend_q;
	cefl_byte_t cf_evt;
	cefl_byte_t cv_evt;
	cefl_byte_t sf_evt;
	logic [2:0] therm_evt;

	cefl_reg_if cf_if ();
	cefl_reg_if cv_if ();
	cefl_reg_if sf_if ();
	cefl_reg_if m1_if ();
	cefl_reg_if m2_if ();

	////////////////////////////////////////////////////////////////////////
	// Address decode
	always_comb begin
		sel = cefl_decode(reg_addr);
	end

	////////////////////////////////////////////////////////////////////////
	// Event vectors in register bit order
	always_comb begin
		cf_evt = 8'h00;
		cf_evt[`CEFL_CF_OVP] = input_overvoltage_event;
		cf_evt[`CEFL_CF_OCP] = battery_overcurrent_event;
		cf_evt[`CEFL_CF_UV] = battery_undervoltage_event;
		cf_evt[`CEFL_CF_COLD:`CEFL_CF_HOT] = {thermistor_cold_entry_event,
			thermistor_cool_entry_event, thermistor_warm_entry_event,
			thermistor_hot_entry_event};
	end

	always_comb begin
		cv_evt = 8'h00;
		cv_evt[`CEFL_CV_ADC] = adc_conversion_done_event;
		cv_evt[`CEFL_CV_CMP1:`CEFL_CV_CMP3] = {comparator_one_cross_event,
			comparator_two_cross_event, comparator_three_cross_event};
		cv_evt[`CEFL_CV_OPEN] = thermistor_open_event;
	end

	always_comb begin
		sf_evt = 8'h00;
		sf_evt[`CEFL_SF_WDOG] = host_watchdog_expiry_event;
		sf_evt[`CEFL_SF_SAFE] = charge_safety_expiry_event;
		sf_evt[`CEFL_SF_LDO] = regulator_overcurrent_event;
		sf_evt[`CEFL_SF_IMAX] = current_limit_pin_open_event;
		sf_evt[`CEFL_SF_WAKE1] = button_wake_first_event;
		sf_evt[`CEFL_SF_WAKE2] = button_wake_second_event;
		sf_evt[`CEFL_SF_RWARN] = button_reset_warning_event;
	end

	assign therm_evt = {thermistor_cold_entry_event,
		thermistor_cool_entry_event, thermistor_hot_entry_event};

	////////////////////////////////////////////////////////////////////////
	// Flag cells: a read of the register clears it
	assign cf_if.evt = cf_evt;
	assign cf_if.rd_clr = reg_rd && (sel == CEFL_SEL_CF);
	assign cf_if.wr = 1'b0;
	assign cf_if.wdata = 8'h00;
	assign cv_if.evt = cv_evt;
	assign cv_if.rd_clr = reg_rd && (sel == CEFL_SEL_CV);
	assign cv_if.wr = 1'b0;
	assign cv_if.wdata = 8'h00;
	assign sf_if.evt = sf_evt;
	assign sf_if.rd_clr = reg_rd && (sel == CEFL_SEL_SF);
	assign sf_if.wr = 1'b0;
	assign sf_if.wdata = 8'h00;

	cefl_flag_latch #(
		.RSVD(`CEFL_CF_RSVD)
	) u_cf (
		.clk(clk),
		.rst_n(rst_n),
		.port(cf_if.latch)
	);

	cefl_flag_latch #(
		.RSVD(`CEFL_CV_RSVD)
	) u_cv (
		.clk(clk),
		.rst_n(rst_n),
		.port(cv_if.latch)
	);

	cefl_flag_latch #(
		.RSVD(`CEFL_SF_RSVD)
	) u_sf (
		.clk(clk),
		.rst_n(rst_n),
		.port(sf_if.latch)
	);

	////////////////////////////////////////////////////////////////////////
	// Mask cells
	assign m1_if.evt = 8'h00;
	assign m1_if.rd_clr = 1'b0;
	assign m1_if.wr = reg_wr && (sel == CEFL_SEL_M1);
	assign m1_if.wdata = reg_wdata;
	assign m2_if.evt = 8'h00;
	assign m2_if.rd_clr = 1'b0;
	assign m2_if.wr = reg_wr && (sel == CEFL_SEL_M2);
	assign m2_if.wdata = reg_wdata;

	cefl_mask_reg #(
		.RST(`CEFL_M1_RST)
	) u_m1 (
		.clk(clk),
		.rst_n(rst_n),
		.port(m1_if.mask)
	);

	cefl_mask_reg #(
		.RST(`CEFL_M2_RST)
	) u_m2 (
		.clk(clk),
		.rst_n(rst_n),
		.port(m2_if.mask)
	);

	////////////////////////////////////////////////////////////////////////
	// Read data: the value before the clear, one cycle after the strobe
	always_comb begin
		rdata_d = `CEFL_UNMAPPED;
		unique case (sel)
			CEFL_SEL_CF: rdata_d = cf_if.value;
			CEFL_SEL_CV: rdata_d = cv_if.value;
			CEFL_SEL_SF: rdata_d = sf_if.value;
			CEFL_SEL_M1: rdata_d = m1_if.value;
			CEFL_SEL_M2: rdata_d = m2_if.value;
			CEFL_SEL_NONE: rdata_d = `CEFL_UNMAPPED;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= `CEFL_RDATA_RST;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unmasked pending events toward the interrupt logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cf_pend_q <= 8'h00;
		end else begin
			cf_pend_q <= cf_if.value & ~m1_if.value;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cv_pend_q <= 8'h00;
		end else begin
			cv_pend_q <= cv_if.value & ~m2_if.value;
		end
	end

	assign reg_rdata = rdata_q;
	assign charge_fault_flags = cf_if.value;
	assign converter_flags = cv_if.value;
	assign system_fault_flags = sf_if.value;
	assign charge_fault_mask = m1_if.value;
	assign converter_event_mask = m2_if.value;
	assign charge_fault_pending = cf_pend_q;
	assign converter_pending = cv_pend_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_cf_read_clear: assert property (
		reg_rd && sel == CEFL_SEL_CF && cf_evt == 8'h00
		|=> charge_fault_flags == 8'h00 && reg_rdata == $past(cf_if.value))
		else $error("Charge fault read did not return and clear");

	a_cv_read_clear: assert property (
		reg_rd && sel == CEFL_SEL_CV && cv_evt == 8'h00
		|=> converter_flags == 8'h00 && reg_rdata == $past(cv_if.value))
		else $error("Converter read did not return and clear");

	a_sf_read_clear: assert property (
		reg_rd && sel == CEFL_SEL_SF && sf_evt == 8'h00
		|=> system_fault_flags == 8'h00 && reg_rdata == $past(sf_if.value))
		else $error("System fault read did not return and clear");

	a_ovp_latch: assert property (
		input_overvoltage_event
		|=> charge_fault_flags[`CEFL_CF_OVP]
		##1 (charge_fault_flags[`CEFL_CF_OVP]
		|| $past(reg_rd && sel == CEFL_SEL_CF)))
		else $error("Overvoltage flag not latched");

	a_ocp_latch: assert property (
		battery_overcurrent_event |=> charge_fault_flags[`CEFL_CF_OCP])
		else $error("Battery overcurrent flag not latched");

	a_uv_latch: assert property (
		battery_undervoltage_event |=> charge_fault_flags[`CEFL_CF_UV])
		else $error("Battery undervoltage flag not latched");

	a_therm_latch: assert property (
		thermistor_warm_entry_event || |therm_evt
		|=> charge_fault_flags[1] == $past(thermistor_warm_entry_event)
		|| $past(charge_fault_flags[1]))
		else $error("Thermistor region flag wrong");

	a_therm_set: assert property (
		|therm_evt |=> ({charge_fault_flags[3:2], charge_fault_flags[0]}
		& $past(therm_evt)) == $past(therm_evt))
		else $error("Thermistor entry flag not latched");

	a_adc_done: assert property (
		adc_conversion_done_event |=> converter_flags[`CEFL_CV_ADC])
		else $error("Conversion done flag not latched");

	a_comp_cross: assert property (
		comparator_two_cross_event |=> converter_flags[5])
		else $error("Comparator flag not latched");

	a_ts_open: assert property (
		thermistor_open_event |=> converter_flags[`CEFL_CV_OPEN])
		else $error("Thermistor open flag not latched");

	a_sys_latch: assert property (
		(sf_evt & ~`CEFL_SF_RSVD) != 8'h00
		|=> (system_fault_flags & $past(sf_evt)) == $past(sf_evt))
		else $error("System fault event not latched");

	a_flag_hold: assert property (
		system_fault_flags[`CEFL_SF_SAFE] && !(reg_rd && sel == CEFL_SEL_SF)
		|=> system_fault_flags[`CEFL_SF_SAFE])
		else $error("Safety timer flag lost without read");

	a_cf_mask_gate: assert property (
		##1 charge_fault_pending
		== ($past(charge_fault_flags) & ~$past(charge_fault_mask)))
		else $error("Charge fault pending not gated by mask");

	a_cv_mask_gate: assert property (
		##1 converter_pending
		== ($past(converter_flags) & ~$past(converter_event_mask)))
		else $error("Converter pending not gated by mask");

	a_event_on_clear: assert property (
		reg_rd && sel == CEFL_SEL_CF && input_overvoltage_event
		|=> charge_fault_flags[`CEFL_CF_OVP]
		##1 (1'b1 [*1]))
		else $error("Event lost during clearing read");

	c_read_with_event: cover property (
		reg_rd && sel == CEFL_SEL_CF && cf_evt != 8'h00);
	c_masked_event: cover property (
		converter_flags[`CEFL_CV_CMP1] && converter_event_mask[6]);
	c_unmapped_read: cover property (reg_rd && sel == CEFL_SEL_NONE);
	c_mask_write: cover property (reg_wr && sel == CEFL_SEL_M2);
endmodule : cefl_event_flags

// ### cefl_event_flags_tb.sv
// Self-checking testbench of the charger event flag latches
`timescale 1ns/1ps
`include "cefl_regs.svh"
module cefl_event_flags_tb
	import cefl_pkg::*;
;
	logic clk;
	logic rst_n;
	cefl_byte_t reg_addr;
	logic reg_rd;
	logic reg_wr;
	cefl_byte_t reg_wdata;
	cefl_byte_t reg_rdata;
	cefl_byte_t ev [0:2];
	cefl_byte_t flags [0:2];
	cefl_byte_t m1;
	cefl_byte_t m2;
	cefl_byte_t p1;
	cefl_byte_t p2;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	cefl_host_model cefl_host_model_inst (.clk(clk), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));

	cefl_event_flags cefl_event_flags_inst (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.input_overvoltage_event(ev[0][7]),
		.battery_overcurrent_event(ev[0][5]),
		.battery_undervoltage_event(ev[0][4]),
		.thermistor_cold_entry_event(ev[0][3]),
		.thermistor_cool_entry_event(ev[0][2]),
		.thermistor_warm_entry_event(ev[0][1]),
		.thermistor_hot_entry_event(ev[0][0]),
		.adc_conversion_done_event(ev[1][7]),
		.comparator_one_cross_event(ev[1][6]),
		.comparator_two_cross_event(ev[1][5]),
		.comparator_three_cross_event(ev[1][4]),
		.thermistor_open_event(ev[1][0]),
		.host_watchdog_expiry_event(ev[2][6]),
		.charge_safety_expiry_event(ev[2][5]),
		.regulator_overcurrent_event(ev[2][4]),
		.current_limit_pin_open_event(ev[2][3]),
		.button_wake_first_event(ev[2][2]),
		.button_wake_second_event(ev[2][1]),
		.button_reset_warning_event(ev[2][0]),
		.charge_fault_flags(flags[0]), .converter_flags(flags[1]),
		.system_fault_flags(flags[2]), .charge_fault_mask(m1),
		.converter_event_mask(m2), .charge_fault_pending(p1),
		.converter_pending(p2));

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input cefl_byte_t exp,
		input cefl_byte_t got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One-cycle event pulse on one flag register's sources
	task automatic pulse(input int i, input cefl_byte_t v);
		@(posedge clk);
		ev[i] <= v;
		@(posedge clk);
		ev[i] <= 8'h00;
		@(negedge clk);
	endtask : pulse

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		cefl_byte_t d;
		@(negedge clk);
		for (int i = 0; i < 3; i++) begin
			chk("flag reset", `CEFL_FLAG_RST, flags[i]);
		end
		chk("charge_fault_mask reset", `CEFL_M1_RST, m1);
		chk("converter_event_mask reset", `CEFL_M2_RST, m2);
		chk("pending1 reset", 8'h00, p1);
		chk("pending2 reset", 8'h00, p2);
		chk("rdata reset", `CEFL_RDATA_RST, reg_rdata);
		cefl_host_model_inst.read(8'h09, d);
		chk("converter_event_mask read", 8'h71, d);
	endtask : t_reset

	// Each source alone, then all sources with reserved bits staying zero
	task automatic t_bits(input int i);
		cefl_byte_t rsvd;
		cefl_byte_t a;
		cefl_byte_t d;
		rsvd = (i == 0) ? `CEFL_CF_RSVD :
			(i == 1) ? `CEFL_CV_RSVD : `CEFL_SF_RSVD;
		a = 8'h04 + cefl_byte_t'(i);
		for (int b = 0; b < 8; b++) begin
			if (!rsvd[b]) begin
				pulse(i, 8'h01 << b);
				repeat (3) @(negedge clk);
				chk("held flag", 8'h01 << b, flags[i]);
				cefl_host_model_inst.read(a, d);
				chk("flag read", 8'h01 << b, d);
				chk("flag cleared", 8'h00, flags[i]);
			end
		end
		pulse(i, 8'hFF);
		cefl_host_model_inst.read(a, d);
		chk("all flags read", ~rsvd, d);
		cefl_host_model_inst.read(a, d);
		chk("second read", 8'h00, d);
	endtask : t_bits

	// Other reads leave flags; event in the clearing cycle survives
	task automatic t_race();
		cefl_byte_t d;
		pulse(0, 8'h21);
		cefl_host_model_inst.read(8'h05, d);
		chk("other read", 8'h21, flags[0]);
		cefl_host_model_inst.rd_start(8'h04);
		ev[0] <= 8'h80;
		@(posedge clk);
		ev[0] <= 8'h00;
		cefl_host_model_inst.rd_done(d);
		chk("race read", 8'h21, d);
		chk("race kept", 8'h80, flags[0]);
		cefl_host_model_inst.read(8'h04, d);
		chk("race next", 8'h80, d);
	endtask : t_race

	task automatic t_mask();
		cefl_byte_t d;
		cefl_host_model_inst.write(8'h08, 8'h20);
		cefl_host_model_inst.write(8'h09, 8'h00);
		cefl_host_model_inst.read(8'h08, d);
		chk("charge_fault_mask read", 8'h20, d);
		pulse(0, 8'h21);
		pulse(1, 8'h81);
		@(negedge clk);
		chk("pending1", 8'h01, p1);
		chk("pending2", 8'h81, p2);
		cefl_host_model_inst.write(8'h09, 8'h80);
		@(negedge clk);
		chk("converter_event_mask out", 8'h80, m2);
		chk("pending2 masked", 8'h01, p2);
		cefl_host_model_inst.write(8'h04, 8'h00);
		chk("flag write", 8'h21, flags[0]);
		cefl_host_model_inst.read(8'h07, d);
		chk("unmapped read", 8'h00, d);
		cefl_host_model_inst.read(8'h05, d);
		chk("cv read", 8'h81, d);
		cefl_host_model_inst.read(8'h04, d);
		chk("cf read", 8'h21, d);
	endtask : t_mask

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			stop_test();
		end
	end

	initial begin
		rst_n = 1'b0;
		for (int i = 0; i < 3; i++) begin
			ev[i] = 8'h00;
		end
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_bits(0);
		t_bits(1);
		t_bits(2);
		t_race();
		t_mask();
		stop_test();
	end
endmodule : cefl_event_flags_tb

// ### cefl_flag_latch.sv
// Clear-on-read event flag register cell
`timescale 1ns/1ps
`include "cefl_regs.svh"
module cefl_flag_latch
	import cefl_pkg::*;
#(
	parameter cefl_byte_t RSVD = 8'h00
) (
	input wire logic clk,
	input wire logic rst_n,
	cefl_reg_if.latch port
);
	cefl_byte_t flags_q;
	cefl_byte_t flags_d;

	////////////////////////////////////////////////////////////////////////
	// Set wins over the clearing read; reserved bits stay zero
	always_comb begin
		flags_d = (port.evt | (flags_q & {8{~port.rd_clr}})) & ~RSVD;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= `CEFL_FLAG_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign port.value = flags_q;

	a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(flags_q & RSVD) == 8'h00)
		else $error("Reserved flag bit set");
endmodule : cefl_flag_latch

// ### cefl_host_model.sv
// Host model that reads and writes the flag registers
`timescale 1ns/1ps
module cefl_host_model
	import cefl_pkg::*;
(
	input wire logic clk,
	output cefl_byte_t reg_addr,
	output logic reg_rd,
	output logic reg_wr,
	output cefl_byte_t reg_wdata,
	input wire cefl_byte_t reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Raises a one-cycle read strobe just after an edge
	task automatic rd_start(input cefl_byte_t a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
	endtask : rd_start

	// Called at the taking edge; releases the port and keeps the byte
	task automatic rd_done(output cefl_byte_t d);
		reg_rd <= 1'b0;
		reg_addr <= ~reg_addr;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd_done

	task automatic read(input cefl_byte_t a, output cefl_byte_t d);
		rd_start(a);
		@(posedge clk);
		rd_done(d);
	endtask : read

	task automatic write(input cefl_byte_t a, input cefl_byte_t d);
		@(posedge clk);
		reg_addr <= a;
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(negedge clk);
	endtask : write
endmodule : cefl_host_model

// ### cefl_mask_reg.sv
// Read-write interrupt mask register cell
`timescale 1ns/1ps
module cefl_mask_reg
	import cefl_pkg::*;
#(
	parameter cefl_byte_t RST = 8'h00
) (
	input wire logic clk,
	input wire logic rst_n,
	cefl_reg_if.mask port
);
	cefl_byte_t mask_q;

	////////////////////////////////////////////////////////////////////////
	// Software write of the whole byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= RST;
		end else if (port.wr) begin
			mask_q <= port.wdata;
		end
	end

	assign port.value = mask_q;

	a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
		port.wr |=> mask_q == $past(port.wdata))
		else $error("Mask write not stored");
endmodule : cefl_mask_reg

// ### cefl_pkg.sv
// Types and address decode shared by the event flag latch block
package cefl_pkg;

`include "cefl_regs.svh"

	typedef logic [7:0] cefl_byte_t;

	typedef enum logic [5:0] {
		CEFL_SEL_NONE = 6'b000001,
		CEFL_SEL_CF = 6'b000010,
		CEFL_SEL_CV = 6'b000100,
		CEFL_SEL_SF = 6'b001000,
		CEFL_SEL_M1 = 6'b010000,
		CEFL_SEL_M2 = 6'b100000
	} cefl_sel_t;

	// Maps a register offset to its one-hot select
	function automatic cefl_sel_t cefl_decode(input cefl_byte_t addr);
		cefl_sel_t sel;
		sel = CEFL_SEL_NONE;
		unique case (addr)
			`CEFL_CF_ADDR: sel = CEFL_SEL_CF;
			`CEFL_CV_ADDR: sel = CEFL_SEL_CV;
			`CEFL_SF_ADDR: sel = CEFL_SEL_SF;
			`CEFL_M1_ADDR: sel = CEFL_SEL_M1;
			`CEFL_M2_ADDR: sel = CEFL_SEL_M2;
			default: sel = CEFL_SEL_NONE;
		endcase
		return sel;
	endfunction : cefl_decode

endpackage : cefl_pkg

// ### cefl_reg_if.sv
// Carrier between the top and one 8-bit register cell
`timescale 1ns/1ps
interface cefl_reg_if;
	import cefl_pkg::*;

	cefl_byte_t evt;
	logic rd_clr;
	logic wr;
	cefl_byte_t wdata;
	cefl_byte_t value;

	modport latch (input evt, input rd_clr, output value);
	modport mask (input wr, input wdata, output value);
	modport ctrl (output evt, output rd_clr, output wr, output wdata,
		input value);
endinterface : cefl_reg_if

// ### cefl_regs.svh
// Offsets, reset values and field positions of the event flag latches
`ifndef CEFL_REGS_SVH
`define CEFL_REGS_SVH

// Register offsets
`define CEFL_CF_ADDR 8'h04
`define CEFL_CV_ADDR 8'h05
`define CEFL_SF_ADDR 8'h06
`define CEFL_M1_ADDR 8'h08
`define CEFL_M2_ADDR 8'h09

// Reset values
`define CEFL_FLAG_RST 8'h00
`define CEFL_M1_RST 8'h00
`define CEFL_M2_RST 8'h71
`define CEFL_RDATA_RST 8'h00
`define CEFL_UNMAPPED 8'h00

// Reserved bits of each flag register, held at zero
`define CEFL_CF_RSVD 8'h40
`define CEFL_CV_RSVD 8'h0E
`define CEFL_SF_RSVD 8'h80

// Charge fault field positions
`define CEFL_CF_OVP 7
`define CEFL_CF_OCP 5
`define CEFL_CF_UV 4
`define CEFL_CF_COLD 3
`define CEFL_CF_HOT 0

// Converter field positions
`define CEFL_CV_ADC 7
`define CEFL_CV_CMP1 6
`define CEFL_CV_CMP3 4
`define CEFL_CV_OPEN 0

// System fault field positions
`define CEFL_SF_WDOG 6
`define CEFL_SF_SAFE 5
`define CEFL_SF_LDO 4
`define CEFL_SF_IMAX 3
`define CEFL_SF_WAKE1 2
`define CEFL_SF_WAKE2 1
`define CEFL_SF_RWARN 0

`endif
